/* rtl/rx_clock_delay_cell.sv */
// Purpose: Receive clock delay cell with fabric trim for margin test
// Assumes: Step and direction are fabric pins, synchronised here
// Notes: Reload restores loop code plus fuse adjustment
`timescale 1ns/1ps
`include "dll_trim_params.svh"
module rx_clock_delay_cell
	import dll_trim_pkg::*;
#(
	parameter int WIDTH = `TRIM_CODE_WIDTH
) (
	// System
	input wire logic clock,
	input wire logic reset,
	// Loop codes from two corner loops
	input wire logic [WIDTH-1:0] loop_code_a,
	input wire logic [WIDTH-1:0] loop_code_b,
	input wire logic loop_select,
	input wire logic [WIDTH-1:0] fuse_adjust,
	// Trim control
	input wire logic delay_reload_n,
	input wire logic trim_step,
	input wire logic trim_direction,
	// Clock path
	input wire logic rx_clock,
	output logic edge_clock_net,
	// Status
	output logic [WIDTH-1:0] delay_setting,
	output logic trim_limit_flag
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int PIN_COUNT = 3;
	localparam int PIN_STEP = 0;
	localparam int PIN_DIR = 1;
	localparam int PIN_EDGE = 2;

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_safe;
	logic clock_delayed;

	// Step, direction and the delayed clock sample
	assign pin_raw[PIN_STEP] = trim_step;
	assign pin_raw[PIN_DIR] = trim_direction;
	assign pin_raw[PIN_EDGE] = clock_delayed;

	// Two flops per pin; only the second stage is read
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_sync
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					pin_meta[g] <= 1'b0;
				end else begin
					pin_meta[g] <= pin_raw[g];
				end
			end

			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					pin_safe[g] <= 1'b0;
				end else begin
					pin_safe[g] <= pin_meta[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Step edge detect
	// ----------------------------------------
	logic step_safe;
	logic dir_safe;
	logic step_last;
	logic step_rise;

	assign step_safe = pin_safe[PIN_STEP];
	assign dir_safe = pin_safe[PIN_DIR];

	// Pin idles low, so no false edge after reset
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			step_last <= 1'b0;
		end else begin
			step_last <= step_safe;
		end
	end

	assign step_rise = step_safe & ~step_last;

	// ----------------------------------------
	// Reload guard
	// ----------------------------------------
	// A step sampled during reload meets the detector after release,
	// so the guard stands one edge beyond the reload itself
	logic reload_active;
	logic reload_prev;
	logic reload_guard;
	logic step_taken;
	trim_state_t state;
	trim_state_t next_state;

	assign reload_active = ~delay_reload_n;
	assign reload_guard = reload_active | reload_prev;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			reload_prev <= 1'b0;
		end else begin
			reload_prev <= reload_active;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			trim_idle: begin
				if (reload_guard) begin
					next_state = trim_held;
				end else if (step_rise) begin
					next_state = trim_stepping;
				end else begin
					next_state = trim_idle;
				end
			end
			trim_stepping: begin
				if (reload_guard) begin
					next_state = trim_held;
				end else if (step_rise) begin
					next_state = trim_stepping;
				end else begin
					next_state = trim_idle;
				end
			end
			trim_held: begin
				if (reload_guard) begin
					next_state = trim_held;
				end else begin
					next_state = trim_idle;
				end
			end
			default: begin
				next_state = trim_held;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= trim_held;
		end else begin
			state <= next_state;
		end
	end

	assign step_taken = step_rise && (state != trim_held) && !reload_active;

	// ----------------------------------------
	// Code source
	// ----------------------------------------
	logic [WIDTH-1:0] base_code;

	// Either adjacent corner loop may feed this edge
	assign base_code = WIDTH'(((loop_select ? loop_code_b : loop_code_a) + fuse_adjust));

	// ----------------------------------------
	// Step arithmetic
	// ----------------------------------------
	logic [WIDTH-1:0] next_setting;
	logic [WIDTH-1:0] next_loaded;

	function automatic logic at_limit(input logic [WIDTH-1:0] code, input logic dir);
		at_limit = (dir == `TRIM_DIR_UP) ? (code == {WIDTH{1'b1}}) : (code == '0);
	endfunction : at_limit

	function automatic logic is_end_code(input logic [WIDTH-1:0] code);
		is_end_code = (code == WIDTH'(`TRIM_MIN_CODE)) || (code == WIDTH'(`TRIM_MAX_CODE));
	endfunction : is_end_code

	always_comb begin
		next_setting = delay_setting;
		if (step_taken && !at_limit(delay_setting, dir_safe)) begin
			if (dir_safe == `TRIM_DIR_UP) begin
				next_setting = WIDTH'(delay_setting + 1'b1);
			end else begin
				next_setting = WIDTH'(delay_setting - 1'b1);
			end
		end
	end

	assign next_loaded = reload_active ? base_code : next_setting;

	// ----------------------------------------
	// Setting register
	// ----------------------------------------
	// Reload loads the base code on every edge while it stands;
	// the taps take it at once through the select below
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			delay_setting <= `TRIM_RESET_CODE;
		end else if (reload_active) begin
			delay_setting <= base_code;
		end else begin
			delay_setting <= next_setting;
		end
	end

	// ----------------------------------------
	// Limit flag
	// ----------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			trim_limit_flag <= 1'b1;
		end else begin
			trim_limit_flag <= is_end_code(next_loaded);
		end
	end

	// ----------------------------------------
	// Delayed clock path
	// ----------------------------------------
	logic [WIDTH-1:0] tap_select;

	// Reload reaches the taps without waiting for a clock edge
	assign tap_select = reload_active ? base_code : delay_setting;

	tap_delay_line #(
		.TAPS(1 << WIDTH)
	) u_taps (
		.clock_in(rx_clock),
		.tap_select(tap_select),
		.clock_out(clock_delayed)
	);

	// Two sync flops above, one more to the port
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			edge_clock_net <= 1'b0;
		end else begin
			edge_clock_net <= pin_safe[PIN_EDGE];
		end
	end
endmodule : rx_clock_delay_cell

/* pkg/dll_trim_params.svh */
// Purpose: Constants for the receive clock delay trim cell
// Assumes: 200 MHz system clock, 8-bit delay setting
// Notes: Types live in dll_trim_pkg
`ifndef DLL_TRIM_PARAMS_SVH
`define DLL_TRIM_PARAMS_SVH

`define TRIM_CODE_WIDTH 8
`define TRIM_MIN_CODE 8'h00
`define TRIM_MAX_CODE 8'hFF
`define TRIM_RESET_CODE 8'h00
`define TRIM_DIR_UP 1'b0
`define TRIM_DIR_DOWN 1'b1
`define TRIM_TAP_COUNT 256

`endif

/* pkg/dll_trim_pkg.sv */
// Purpose: Types for the receive clock delay trim cell
// Assumes: Constants come from dll_trim_params.svh
// Notes: None
package dll_trim_pkg;
	typedef enum logic [1:0] {
		trim_idle = 2'b00,
		trim_stepping = 2'b01,
		trim_held = 2'b11
	} trim_state_t;
	typedef logic [7:0] trim_code_t;
endpackage : dll_trim_pkg

/* rtl/tap_delay_line.sv */
// Purpose: Tapped delay line model for the receive clock
// Assumes: Setting selects one of the tap outputs
// Notes: Tap 0 is the undelayed clock
`timescale 1ns/1ps
`include "dll_trim_params.svh"
module tap_delay_line #(
	parameter int TAPS = `TRIM_TAP_COUNT
) (
	// Clock path
	input wire logic clock_in,
	// Tap select
	input wire logic [$clog2(TAPS)-1:0] tap_select,
	// Delayed clock
	output logic clock_out
);
	logic [TAPS-1:0] chain;
	assign chain[0] = clock_in;
	genvar i;
	generate
		for (i = 1; i < TAPS; i++) begin : g_tap
			// One buffer stage per tap
			assign chain[i] = chain[i-1];
		end
	endgenerate
	assign clock_out = chain[tap_select];
endmodule : tap_delay_line

/* test/trim_checker_sva.sv */
// Purpose: Port checks for the trim cell
// Assumes: One clock domain
// Notes: Bound after the module
`timescale 1ns/1ps
module trim_checker (
	input wire logic clock, reset, loop_select, delay_reload_n, trim_step, trim_direction, trim_limit_flag,
	input wire logic [7:0] loop_code_a, loop_code_b, fuse_adjust, delay_setting
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence keep_s; delay_reload_n && $past(delay_reload_n); endsequence
	sequence up_s; $rose(trim_step) && !trim_direction && delay_reload_n; endsequence
	flag_level_a: assert property (trim_limit_flag == (delay_setting inside {8'h00, 8'hFF}))
		else $error("flag");
	reload_base_a: assert property (!reset && !delay_reload_n |=> delay_setting == 8'(($past(loop_select) ?
		$past(loop_code_b) : $past(loop_code_a)) + $past(fuse_adjust))) else $error("reload");
	one_tap_a: assert property (keep_s ##0 $changed(delay_setting) |->
		8'(delay_setting - $past(delay_setting)) inside {8'h01, 8'hFF}) else $error("tap");
	no_wrap_up_a: assert property (keep_s ##0 $past(delay_setting) == 8'hFF |-> delay_setting != 8'h00)
		else $error("wrap");
	no_wrap_down_a: assert property (keep_s ##0 $past(delay_setting) == 8'h00 |-> delay_setting != 8'hFF)
		else $error("wrap");
	dir_up_a: assert property (keep_s ##0 delay_setting == 8'($past(delay_setting) + 8'h01) |->
		!$past(trim_direction, 3)) else $error("dir");
	dir_down_a: assert property (keep_s ##0 delay_setting == 8'($past(delay_setting) - 8'h01) |->
		$past(trim_direction, 3)) else $error("dir");
	step_move_a: assert property (up_s ##0 delay_setting < 8'hFE |-> ##[1:4] $changed(delay_setting))
		else $error("step");
endmodule : trim_checker
bind rx_clock_delay_cell trim_checker chk_u (.*);

/* test/trim_fabric_model.sv */
// Purpose: Fabric logic issuing trim pulses
// Assumes: Direction set two cycles before the pulse
// Notes: hold stretches the pulse
`timescale 1ns/1ps
module trim_fabric_model (
	// System
	input wire logic clock, reset,
	// Request
	input wire logic req, req_dir,
	input wire logic [1:0] hold,
	// Trim pins
	output logic trim_step, trim_direction, busy
);
	logic [3:0] count;
	assign trim_step = busy && count >= 4'h2 && count < 4'h4 + 4'(hold);
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			count <= 4'h0;
			trim_direction <= 1'b0;
		end else if (!busy) begin
			busy <= req;
			count <= 4'h0;
			if (req) trim_direction <= req_dir;
		end else begin
			count <= count + 4'h1;
			busy <= count != 4'h8 + 4'(hold);
		end
	end
endmodule : trim_fabric_model

/* test/tb.sv */
// Purpose: Trim cell testbench
// Assumes: Base code 70h (loop A) or F0h (loop B) plus fuse
// Notes: Rows run cumulatively
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("FAIL %0t got %h", $time, a); end end
module tb;
	import dll_trim_pkg::*;
	logic clock = 0, reset = 1, rx_clock = 0, loop_select = 0, delay_reload_n = 0, req = 0, req_dir = 0;
	logic [1:0] hold = 0;
	trim_code_t loop_code_a = 8'h70, loop_code_b = 8'hF0, fuse_adjust = 8'h10, delay_setting;
	logic trim_step, trim_direction, busy, edge_clock_net, trim_limit_flag;
	int n_errors = 0, cmp_count = 0;
	typedef struct {logic dir; int n; trim_code_t exp;} row_t;
	row_t rows[3] = '{'{1'b0, 3, 8'h83}, '{1'b1, 5, 8'h7E}, '{1'b0, 1, 8'h7F}};
	initial forever #2.5 clock = ~clock;
	initial forever #3 rx_clock = ~rx_clock;
	logic [2:0] rx_hist = 3'h0;
	always @(posedge clock) rx_hist <= {rx_hist[1:0], rx_clock};
	rx_clock_delay_cell dut_u (.*);
	trim_fabric_model fab_u (.*);
	task print_verdict;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	task step(input logic d, input int n);
		repeat (n) begin
			@(posedge clock);
			req <= 1'b1;
			req_dir <= d;
			hold <= hold + 2'h1;
			@(posedge clock);
			req <= 1'b0;
			@(negedge clock);
			for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clock);
			if (busy !== 1'b0) begin
				n_errors++;
				print_verdict;
			end
		end
	endtask : step
	task load(input logic s, input trim_code_t f);
		@(posedge clock);
		loop_select <= s;
		fuse_adjust <= f;
		delay_reload_n <= 1'b0;
		repeat (2) @(posedge clock);
		delay_reload_n <= 1'b1;
		@(negedge clock);
	endtask : load
	initial begin
		repeat (19) @(posedge clock);
		@(negedge clock);
		`CHK({delay_setting, trim_limit_flag}, 9'h001)
		@(posedge clock) reset <= 1'b0;
		load(1'b0, 8'h10);
		`CHK(delay_setting, 8'h80)
		foreach (rows[i]) begin
			step(rows[i].dir, rows[i].n);
			`CHK(delay_setting, rows[i].exp)
		end
		repeat (6) begin
			@(negedge clock);
			`CHK(edge_clock_net, rx_hist[2])
		end
		$display("rows done");
		load(1'b1, 8'h0E);
		step(1'b0, 1);
		`CHK({delay_setting, trim_limit_flag}, 9'h1FF)
		step(1'b0, 2);
		`CHK(delay_setting, 8'hFF)
		load(1'b1, 8'h20);
		@(posedge clock) delay_reload_n <= 1'b0;
		step(1'b0, 2);
		`CHK(delay_setting, 8'h10)
		fork
			step(1'b0, 1);
			begin
				repeat (5) @(posedge clock);
				delay_reload_n <= 1'b1;
			end
		join
		`CHK(delay_setting, 8'h10)
		load(1'b0, 8'h91);
		step(1'b1, 3);
		`CHK({delay_setting, trim_limit_flag}, 9'h001)
		step(1'b0, 1);
		`CHK(delay_setting, 8'h01)
		$display("limits done");
		print_verdict;
	end
endmodule : tb
